/* bba_core.sv */
// Byte and bit operation datapath with a classic Wishbone register slave
//
// Behaviour
// RL1: add immediate into accumulator, update carry, digit carry, zero
// RL2: AND accumulator with file, destination select, zero only
// RL3: add accumulator and file, destination select, all flags
// RL4: clear selected file bit, flags untouched
// RL5: set selected file bit, flags untouched
// RL6: AND immediate into accumulator, zero only
// RL7: skip next instruction when tested bit is one
// RL8: skip next instruction when tested bit is zero
// RL9: clear file register and set zero flag
// RL10: instruction cycle is four clocks, one cycle each
// RL11: bit operations decoded from two-bit code field
// RL12: zero on zero result, carries from bits 7, 3
// RL13: flag update overrides result written to status file
`timescale 1ns/1ns
module bba_core (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic skip_o
);
	logic [1:0] div_ff;
	logic cycle_tick;
	logic pend_ff;
	logic skip_ff;
	logic illegal_ff;
	logic ack_ff;
	logic [31:0] rdat_ff;
	logic [13:0] instr_ff;
	logic [7:0] acc_ff;
	logic [6:0] faddr_ff;
	logic [7:0] file_ff [bba_pkg::FILE_DEPTH];
	logic [7:0] nxt_file [bba_pkg::FILE_DEPTH];
	logic [7:0] status_val;
	bba_pkg::bba_alu_s alu;
	logic exec;
	logic apply;
	logic bus_req;
	logic bus_take;
	logic bus_wr;
	logic [31:0] rd_mux;

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdat_ff;
	assign skip_o = skip_ff;
	assign status_val = file_ff[bba_pkg::STATUS_ADDR];

	// Instruction cycle enable every four clocks
	assign cycle_tick = (div_ff == bba_pkg::DIV_LAST); // RL10
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			div_ff <= 2'h0;
		end else begin
			div_ff <= div_ff + 2'h1;
		end
	end

	// A pending instruction runs on the next tick; a skipped one runs as a no-op
	assign exec = pend_ff && cycle_tick; // RL10
	assign apply = exec && !skip_ff; // RL7 RL8

	bba_alu u_alu (
		.instr(instr_ff),
		.acc(acc_ff),
		.fval(file_ff[instr_ff[6:0]]),
		.alu(alu)
	);

	// Writes wait while an instruction is pending so they never meet execution
	assign bus_req = wb_cyc_i && wb_stb_i && !ack_ff;
	assign bus_take = bus_req && (!wb_we_i || !pend_ff);
	assign bus_wr = bus_take && wb_we_i;

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= bus_take;
		end
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (wb_adr_i)
			bba_pkg::OFS_INSTR: rd_mux = {18'h00000, instr_ff};
			bba_pkg::OFS_ACC: rd_mux = {24'h000000, acc_ff};
			bba_pkg::OFS_STAT: begin
				rd_mux[bba_pkg::STB_CARRY] = status_val[bba_pkg::FLG_CARRY];
				rd_mux[bba_pkg::STB_DCARRY] = status_val[bba_pkg::FLG_DCARRY];
				rd_mux[bba_pkg::STB_ZERO] = status_val[bba_pkg::FLG_ZERO];
				rd_mux[bba_pkg::STB_PEND] = pend_ff;
				rd_mux[bba_pkg::STB_SKIP] = skip_ff;
				rd_mux[bba_pkg::STB_ILLEGAL] = illegal_ff;
			end
			bba_pkg::OFS_FADDR: rd_mux = {25'h0000000, faddr_ff};
			bba_pkg::OFS_FDATA: rd_mux = {24'h000000, file_ff[faddr_ff]};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdat_ff <= 32'h0000_0000;
		end else if (bus_take && !wb_we_i) begin
			rdat_ff <= rd_mux;
		end
	end

	// Instruction issue and pending state
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			instr_ff <= bba_pkg::INSTR_RST;
			pend_ff <= 1'b0;
		end else if (bus_wr && wb_adr_i == bba_pkg::OFS_INSTR && wb_sel_i[1:0] == 2'h3) begin
			instr_ff <= wb_dat_i[13:0];
			pend_ff <= 1'b1;
		end else if (exec) begin
			pend_ff <= 1'b0;
		end
	end

	// Skip is armed by a true test and consumed by the next executed instruction
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			skip_ff <= 1'b0;
		end else if (exec) begin
			skip_ff <= apply && alu.skip; // RL7 RL8
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			illegal_ff <= 1'b0;
		end else if (apply) begin
			illegal_ff <= alu.illegal;
		end
	end

	// Accumulator
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			acc_ff <= bba_pkg::ACC_RST;
		end else if (apply && alu.wr_acc) begin
			acc_ff <= alu.res; // RL1 RL6
		end else if (bus_wr && wb_adr_i == bba_pkg::OFS_ACC && wb_sel_i[0]) begin
			acc_ff <= wb_dat_i[7:0];
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			faddr_ff <= 7'h00;
		end else if (bus_wr && wb_adr_i == bba_pkg::OFS_FADDR && wb_sel_i[0]) begin
			faddr_ff <= wb_dat_i[6:0];
		end
	end

	// File register space, one entry per index
	for (genvar i = 0; i < bba_pkg::FILE_DEPTH; i++) begin : g_file
		always_comb begin
			nxt_file[i] = file_ff[i];
			if (apply && alu.wr_file && alu.faddr == 7'(i)) begin
				nxt_file[i] = alu.res; // RL2 RL3 RL4 RL5 RL9
			end else if (bus_wr && wb_adr_i == bba_pkg::OFS_FDATA && wb_sel_i[0]
					&& faddr_ff == 7'(i)) begin
				nxt_file[i] = wb_dat_i[7:0];
			end
			// Flag updates land after the result so they win in the status entry
			if (7'(i) == bba_pkg::STATUS_ADDR && apply) begin
				if (alu.upd_c) begin
					nxt_file[i][bba_pkg::FLG_CARRY] = alu.c; // RL13 RL12
				end
				if (alu.upd_dc) begin
					nxt_file[i][bba_pkg::FLG_DCARRY] = alu.dc; // RL13 RL12
				end
				if (alu.upd_z) begin
					nxt_file[i][bba_pkg::FLG_ZERO] = alu.z; // RL13 RL12 RL9
				end
			end
		end
		always_ff @(posedge core_clk or posedge sys_rst) begin
			if (sys_rst) begin
				file_ff[i] <= bba_pkg::FILE_RST;
			end else begin
				file_ff[i] <= nxt_file[i];
			end
		end
	end
endmodule

/* bba_pkg.sv */
// Shared constants and types for the byte and bit operation datapath
package bba_pkg;
	// Clock and instruction cycle
	localparam int CLK_HZ = 50000000;
	localparam int OSC_PER_CYCLE = 4;
	localparam logic [1:0] DIV_LAST = 2'(OSC_PER_CYCLE - 1);

	// Bus register byte offsets
	localparam logic [7:0] OFS_INSTR = 8'h00;
	localparam logic [7:0] OFS_ACC = 8'h04;
	localparam logic [7:0] OFS_STAT = 8'h08;
	localparam logic [7:0] OFS_FADDR = 8'h0c;
	localparam logic [7:0] OFS_FDATA = 8'h10;

	// Bus status register bit positions
	localparam int STB_CARRY = 0;
	localparam int STB_DCARRY = 1;
	localparam int STB_ZERO = 2;
	localparam int STB_PEND = 3;
	localparam int STB_SKIP = 4;
	localparam int STB_ILLEGAL = 5;

	// File register space, status flags and reset values
	localparam int FILE_DEPTH = 128;
	localparam logic [6:0] STATUS_ADDR = 7'h03;
	localparam int FLG_CARRY = 0;
	localparam int FLG_DCARRY = 1;
	localparam int FLG_ZERO = 2;
	localparam logic [7:0] FILE_RST = 8'h00;
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic [13:0] INSTR_RST = 14'h0000;

	// Instruction word classes and sub-codes
	localparam logic [1:0] CLS_BYTE = 2'h0;
	localparam logic [1:0] CLS_BIT = 2'h1;
	localparam logic [1:0] CLS_LIT = 2'h3;
	localparam logic [3:0] SUB_ADD_FILE = 4'h7;
	localparam logic [3:0] SUB_AND_FILE = 4'h5;
	localparam logic [3:0] SUB_CLR_FILE = 4'h1;
	localparam logic [2:0] SUB_ADD_IMM = 3'h7;
	localparam logic [3:0] SUB_AND_IMM = 4'h9;

	typedef enum logic [1:0] {
		BOP_CLEAR = 2'b00,
		BOP_SET = 2'b01,
		BOP_SKIP_CLR = 2'b10,
		BOP_SKIP_SET = 2'b11
	} bba_bop_e;

	// Result of one executed instruction
	typedef struct packed {
		logic [7:0] res;
		logic [6:0] faddr;
		logic wr_acc;
		logic wr_file;
		logic upd_c;
		logic upd_dc;
		logic upd_z;
		logic c;
		logic dc;
		logic z;
		logic skip;
		logic illegal;
	} bba_alu_s;
endpackage

/* bba_alu.sv */
// Combinational decode and arithmetic for one instruction word
`timescale 1ns/1ns
module bba_alu (
	input wire logic [13:0] instr,
	input wire logic [7:0] acc,
	input wire logic [7:0] fval,
	output bba_pkg::bba_alu_s alu
);
	logic [8:0] sum;
	logic [4:0] low_sum;
	logic [7:0] opnd;
	logic [7:0] bit_mask;
	logic bit_val;

	always_comb begin
		alu = '0;
		alu.faddr = instr[6:0];
		opnd = (instr[13:12] == bba_pkg::CLS_LIT) ? instr[7:0] : fval;
		sum = {1'b0, acc} + {1'b0, opnd};
		low_sum = {1'b0, acc[3:0]} + {1'b0, opnd[3:0]};
		bit_mask = 8'h01 << instr[9:7];
		bit_val = |(fval & bit_mask);
		case (instr[13:12])
			bba_pkg::CLS_BYTE: begin
				if (instr[11:8] == bba_pkg::SUB_ADD_FILE) begin
					alu.res = sum[7:0]; // RL3
					alu.wr_acc = ~instr[7];
					alu.wr_file = instr[7];
					{alu.upd_c, alu.upd_dc, alu.upd_z} = 3'h7;
				end else if (instr[11:8] == bba_pkg::SUB_AND_FILE) begin
					alu.res = acc & fval; // RL2
					alu.wr_acc = ~instr[7];
					alu.wr_file = instr[7];
					alu.upd_z = 1'b1;
				end else if (instr[11:8] == bba_pkg::SUB_CLR_FILE && instr[7]) begin
					alu.res = 8'h00; // RL9
					alu.wr_file = 1'b1;
					alu.upd_z = 1'b1;
				end else begin
					alu.illegal = 1'b1;
				end
			end
			bba_pkg::CLS_BIT: begin
				case (bba_pkg::bba_bop_e'(instr[11:10])) // RL11
					bba_pkg::BOP_CLEAR: begin
						alu.res = fval & ~bit_mask; // RL4
						alu.wr_file = 1'b1;
					end
					bba_pkg::BOP_SET: begin
						alu.res = fval | bit_mask; // RL5
						alu.wr_file = 1'b1;
					end
					bba_pkg::BOP_SKIP_CLR: alu.skip = ~bit_val; // RL8
					bba_pkg::BOP_SKIP_SET: alu.skip = bit_val; // RL7
					default: alu.illegal = 1'b1;
				endcase
			end
			bba_pkg::CLS_LIT: begin
				if (instr[11:9] == bba_pkg::SUB_ADD_IMM) begin
					alu.res = sum[7:0]; // RL1
					alu.wr_acc = 1'b1;
					{alu.upd_c, alu.upd_dc, alu.upd_z} = 3'h7;
				end else if (instr[11:8] == bba_pkg::SUB_AND_IMM) begin
					alu.res = acc & instr[7:0]; // RL6
					alu.wr_acc = 1'b1;
					alu.upd_z = 1'b1;
				end else begin
					alu.illegal = 1'b1;
				end
			end
			default: alu.illegal = 1'b1;
		endcase
		alu.c = sum[8]; // RL12
		alu.dc = low_sum[4];
		alu.z = (alu.res == 8'h00);
	end
endmodule

/* bba_core_properties.sv */
// Bus timing, read value and skip timing checks for the byte and bit datapath
`timescale 1ns/1ns
module bba_core_properties (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic skip_o
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	sequence s_rd_take;
		wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
	endsequence
	sequence s_instr_ack;
		wb_ack_o && wb_we_i && wb_adr_i == bba_pkg::OFS_INSTR;
	endsequence
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	a_read_prompt: assert property (s_rd_take |=> wb_ack_o) else $error("slow read");
	a_unmapped_zero: assert property (s_rd_take ##0 wb_adr_i == 8'h20 |=> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	a_stat_upper: assert property (s_rd_take ##0 wb_adr_i == bba_pkg::OFS_STAT
		|=> wb_dat_o[31:6] == 26'h0) else $error("status upper bits set");
	a_dat_hold: assert property (!(wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o)
		|=> $stable(wb_dat_o)) else $error("read data moved");
	a_write_bound: assert property (
		wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o |-> ##[1:6] wb_ack_o)
		else $error("write not answered");
	a_skip_cleared: assert property (s_instr_ack ##0 skip_o |-> ##[1:5] !skip_o)
		else $error("skip not consumed");
	a_skip_quiet: assert property ((!wb_cyc_i) [*6] |-> $stable(skip_o))
		else $error("skip changed while idle");
endmodule
bind bba_core bba_core_properties u_props (.core_clk(core_clk), .sys_rst(sys_rst),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .skip_o(skip_o));

/* bba_wb_master.sv */
// Classic Wishbone master standing in for the sequencer
`timescale 1ns/1ns
module bba_wb_master (
	input wire logic clk,
	input wire logic ack,
	output logic cyc,
	output logic stb,
	output logic we,
	output logic [7:0] adr,
	output logic [3:0] sel,
	output logic [31:0] wdat
);
	initial {cyc, stb, we, adr, sel, wdat} = '0;
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		{cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, 4'hf, d};
		// Only the bench watchdog ends a wait that never sees ack
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		// Released lines show the inverse so stale values cannot pass
		{cyc, stb, adr, wdat} <= {2'b00, ~a, ~d};
	endtask
endmodule

/* bba_core_tb.sv */
// Self-checking bench for the byte and bit datapath
`timescale 1ns/1ns
module bba_core_tb;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic cyc, stb, we, ack, skip, skp, bad;
	logic [7:0] adr, acc;
	logic [3:0] sel;
	logic [31:0] wdat, rdat;
	logic [32:0] exp_q[$];
	logic [7:0] fr[128];
	logic [31:0] rnd = 32'ha681;
	int num_errors = 0;
	int checked = 0;
	always #10 core_clk = ~core_clk;
	bba_wb_master mst (.clk(core_clk), .ack(ack), .cyc(cyc), .stb(stb), .we(we),
		.adr(adr), .sel(sel), .wdat(wdat));
	bba_core DUT (.core_clk(core_clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .skip_o(skip));
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function automatic void exec(input logic [13:0] w);
		logic [7:0] f, o, r;
		logic [8:0] s;
		logic [4:0] h;
		int kind;
		f = fr[w[6:0]];
		o = w[13] ? w[7:0] : f;
		s = acc + o;
		h = acc[3:0] + o[3:0];
		if (!skp)
			bad = !(w[13:12] == 2'b01 || w[13:9] == 5'h1f || w[13:8] inside {6'h07, 6'h39, 6'h05}
				|| w[13:7] == 7'h03);
		kind = 0;
		if (skp)
			skp = 1'b0;
		else if (w[13:12] == 2'b01) begin
			case (w[11:10])
				2'b00: fr[w[6:0]][w[9:7]] = 1'b0;
				2'b01: fr[w[6:0]][w[9:7]] = 1'b1;
				2'b10: skp = !f[w[9:7]];
				default: skp = f[w[9:7]];
			endcase
		end else if (w[13:9] == 5'h1f || w[13:8] == 6'h07)
			kind = 2;
		else if (w[13:8] == 6'h39 || w[13:8] == 6'h05)
			kind = 1;
		else if (w[13:7] == 7'h03)
			kind = 3;
		r = kind == 2 ? s[7:0] : (kind == 1 ? acc & o : 8'h00);
		if (kind > 0) begin
			if (!w[13] && w[7])
				fr[w[6:0]] = r;
			else
				acc = r;
			fr[3][2] = r == 8'h00;
			if (kind == 2)
				fr[3][1:0] = {h[4], s[8]};
		end
	endfunction
	task automatic cmp_word(input logic [32:0] e, input logic [32:0] s);
		checked++;
		if (s !== e) begin
			num_errors++;
			$display("MISMATCH skip_and_read_data expected %h seen %h", e, s);
		end
	endtask
	always @(posedge core_clk)
		if (cyc && stb && !we && ack === 1'b1)
			cmp_word(exp_q.size() ? exp_q.pop_front() : 33'bx, {skip, rdat});
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back({skp, e});
		mst.xfer(1'b0, a, 32'h0);
	endtask
	task automatic check_all(input logic [6:0] a);
		rd(bba_pkg::OFS_ACC, {24'h0, acc});
		rd(bba_pkg::OFS_STAT, {26'h0, bad, skp, 1'b0, fr[3][2:0]});
		mst.xfer(1'b1, bba_pkg::OFS_FADDR, {25'h0, a});
		rd(bba_pkg::OFS_FDATA, {24'h0, fr[a]});
	endtask
	task automatic complete_run();
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (30000) @(posedge core_clk);
		num_errors++;
		complete_run();
	end
	initial begin
		logic [13:0] w;
		logic [6:0] fa;
		int op;
		foreach (fr[i]) fr[i] = 8'h00;
		acc = 8'h00;
		skp = 1'b0;
		bad = 1'b0;
		repeat (20) @(posedge core_clk);
		sys_rst <= 1'b0;
		check_all(7'h03);
		rd(8'h20, 32'h0);
		for (int i = 0; i < 48; i++) begin
			rnd = lfsr(rnd);
			fa = {rnd[20], 4'h0, rnd[11:10]};
			op = i < 9 ? i : rnd[30:27] % 9;
			acc = rnd[19:12];
			mst.xfer(1'b1, bba_pkg::OFS_ACC, {24'h0, acc});
			fr[fa] = rnd[31:24];
			mst.xfer(1'b1, bba_pkg::OFS_FADDR, {25'h0, fa});
			mst.xfer(1'b1, bba_pkg::OFS_FDATA, {24'h0, fr[fa]});
			case (op)
				0: w = {5'h1f, rnd[8:0]};
				1: w = {6'h39, rnd[7:0]};
				2: w = {6'h07, rnd[7], fa};
				3: w = {6'h05, rnd[7], fa};
				4: w = {7'h03, fa};
				default: w = {2'b01, 2'(op - 5), rnd[14:12], fa};
			endcase
			mst.xfer(1'b1, bba_pkg::OFS_INSTR, {18'h0, w});
			exec(w);
			repeat (5) @(posedge core_clk);
			check_all(fa);
		end
		// Consume any armed skip, then an unsupported word must flag and do nothing
		w = {6'h39, 8'hff};
		mst.xfer(1'b1, bba_pkg::OFS_INSTR, {18'h0, w});
		exec(w);
		repeat (5) @(posedge core_clk);
		mst.xfer(1'b1, bba_pkg::OFS_INSTR, {18'h0, 14'h2a5c});
		exec(14'h2a5c);
		repeat (5) @(posedge core_clk);
		check_all(7'h03);
		// A write straight after an issue waits for execution, then lands on top
		rnd = lfsr(rnd);
		w = {6'h39, rnd[7:0]};
		mst.xfer(1'b1, bba_pkg::OFS_INSTR, {18'h0, w});
		exec(w);
		acc = rnd[23:16];
		mst.xfer(1'b1, bba_pkg::OFS_ACC, {24'h0, acc});
		check_all(7'h03);
		complete_run();
	end
endmodule
